// File: src/nand_device.sv
// What this block does
// - Identify command returns five bytes in order
// - Fourth byte: page, spare, block, width
// - Fifth byte: ECC, planes, plane size, zero
// - Host reads: setup, five addresses, confirm
// - Read setup command latched after power-up reset, not after reset command
// - Confirm fetches page, busy until done
// - Each output pulse gives next column until the last, which then repeats
// - Random output column change whenever ready, repeatable
// - Host: at most four partial programs
// - Host programs pages in ascending order
// - Host program: command, addresses, data load
// - Unloaded columns stay unprogrammed
// - Random input column change while loading
// - Program confirm only after data input
// - While programming only status, reset accepted
// - Completion on busy pin and status
// - Status bit0 pass/fail after verify
// - After program, reads return status
// - Status: fail, ready, write-protect bits
// - Busy low during fetch and program
`timescale 1ns/1ps
module nand_device #(
   parameter int FETCH_CYCLES = nand_pkg::FETCH_CYC,
   parameter int PROG_CYCLES = nand_pkg::PROG_CYC
) (
   input logic mclk,
   input logic nrst,
   nand_link.device link,
   output logic busy
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [1:0] {OUT_DATA, OUT_ID, OUT_STATUS} out_e;
   typedef enum logic [1:0] {OP_IDLE, OP_FETCH, OP_PROG, OP_RST} op_e;
   typedef logic [nand_pkg::COLS-1:0][7:0] page_t;

   typedef struct packed {
      logic [nand_pkg::ARRAY_PAGES-1:0][nand_pkg::COLS-1:0][7:0] cells;
      page_t pageReg;
      logic [7:0] lastCmd;
      logic [2:0] addrCount;
      logic [nand_pkg::COL_W-1:0] col;
      logic page;
      out_e outSel;
      op_e op;
      logic [15:0] timer;
      logic [2:0] idIdx;
      logic loaded;
      logic fail;
      logic prevLatchN;
      logic prevPulseN;
      logic [7:0] dout;
   } dev_s;

   dev_s s;
   dev_s next_s;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] idByte(input logic [2:0] idx);
      unique case (idx)
         3'd0: idByte = nand_pkg::ID_MAKER;
         3'd1: idByte = nand_pkg::ID_DEVICE;
         3'd2: idByte = nand_pkg::ID_BYTE3;
         3'd3: idByte = nand_pkg::ID_BYTE4;
         default: idByte = nand_pkg::ID_BYTE5;
      endcase
   endfunction : idByte

   // Cells only go from one to zero; a bit that should be zero but stays one fails
   function automatic logic verifyFail(input page_t want, input page_t got);
      verifyFail = |(~want & got);
   endfunction : verifyFail

   function automatic logic [nand_pkg::COL_W-1:0] colInc(input logic [nand_pkg::COL_W-1:0] c);
      colInc = nand_pkg::COL_W'(c + 1'b1);
   endfunction : colInc

   logic latchRise;
   logic pulseFall;
   logic [7:0] din;
   logic [7:0] statusByte;
   logic colValid;

   assign latchRise = link.latchStrobeN && !s.prevLatchN;
   assign pulseFall = !link.outputPulseN && s.prevPulseN;
   assign din = link.ioLine;
   assign busy = (s.op != OP_IDLE);
   assign colValid = (s.col < nand_pkg::COL_W'(nand_pkg::COLS));
   assign statusByte = {link.wpN, !busy, 5'h00, s.fail};

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.prevLatchN = link.latchStrobeN;
      next_s.prevPulseN = link.outputPulseN;

      if (busy)
      begin
         if (s.timer == 16'h0000)
         begin
            next_s.op = OP_IDLE;
            if (s.op == OP_FETCH)
            begin
               next_s.pageReg = s.cells[s.page];
            end
            else if (s.op == OP_PROG)
            begin
               // Erased fill of unloaded columns leaves those cells alone
               next_s.cells[s.page] = s.cells[s.page] & s.pageReg;
               next_s.fail = verifyFail(s.pageReg, s.cells[s.page] & s.pageReg);
            end
         end
         else
         begin
            next_s.timer = s.timer - 16'h0001;
         end
      end

      if (latchRise && link.cmdCycle)
      begin
         if (!busy || din == nand_pkg::CMD_STATUS || din == nand_pkg::CMD_RESET)
         begin
            unique case (din)
               nand_pkg::CMD_READ:
               begin
                  next_s.lastCmd = din;
                  next_s.addrCount = 3'd0;
                  next_s.outSel = OUT_DATA;
               end
               nand_pkg::CMD_READ_GO:
               begin
                  if (s.lastCmd == nand_pkg::CMD_READ && s.addrCount == 3'(nand_pkg::ADDR_CYCLES))
                  begin
                     next_s.lastCmd = din;
                     next_s.op = OP_FETCH;
                     next_s.timer = 16'(FETCH_CYCLES - 1);
                     next_s.outSel = OUT_DATA;
                  end
               end
               nand_pkg::CMD_RAND_OUT:
               begin
                  next_s.lastCmd = din;
                  next_s.addrCount = 3'd0;
               end
               nand_pkg::CMD_RAND_OUT_GO:
               begin
                  if (s.lastCmd == nand_pkg::CMD_RAND_OUT)
                  begin
                     next_s.lastCmd = din;
                     next_s.outSel = OUT_DATA;
                  end
               end
               nand_pkg::CMD_LOAD:
               begin
                  next_s.lastCmd = din;
                  next_s.addrCount = 3'd0;
                  next_s.pageReg = {nand_pkg::COLS{nand_pkg::ERASED}};
                  next_s.loaded = 1'b1;
               end
               nand_pkg::CMD_RAND_IN:
               begin
                  if (s.loaded)
                  begin
                     next_s.lastCmd = din;
                     next_s.addrCount = 3'd0;
                  end
               end
               nand_pkg::CMD_PROG_GO:
               begin
                  if (s.loaded)
                  begin
                     next_s.lastCmd = din;
                     next_s.loaded = 1'b0;
                     next_s.op = OP_PROG;
                     next_s.timer = 16'(PROG_CYCLES - 1);
                     next_s.outSel = OUT_STATUS;
                  end
               end
               nand_pkg::CMD_STATUS:
               begin
                  next_s.outSel = OUT_STATUS;
               end
               nand_pkg::CMD_ID:
               begin
                  next_s.lastCmd = din;
                  next_s.addrCount = 3'd0;
               end
               nand_pkg::CMD_RESET:
               begin
                  // Aborts any operation; a cut program leaves the array untouched
                  next_s.lastCmd = din;
                  next_s.loaded = 1'b0;
                  next_s.fail = 1'b0;
                  next_s.outSel = OUT_STATUS;
                  next_s.op = OP_RST;
                  next_s.timer = 16'(nand_pkg::RST_CYC - 1);
               end
               default:
               begin
                  next_s.lastCmd = s.lastCmd;
               end
            endcase
         end
      end
      else if (latchRise && link.addrCycle && !busy)
      begin
         if (s.lastCmd == nand_pkg::CMD_ID)
         begin
            if (din == nand_pkg::ID_ADDR)
            begin
               next_s.outSel = OUT_ID;
               next_s.idIdx = 3'd0;
            end
         end
         else if (s.lastCmd == nand_pkg::CMD_READ || s.lastCmd == nand_pkg::CMD_LOAD ||
                  s.lastCmd == nand_pkg::CMD_RAND_OUT || s.lastCmd == nand_pkg::CMD_RAND_IN)
         begin
            if (s.addrCount < 3'(nand_pkg::ADDR_CYCLES))
            begin
               next_s.addrCount = s.addrCount + 3'd1;
            end
            unique case (s.addrCount)
               3'd0: next_s.col[7:0] = din;
               3'd1: next_s.col[nand_pkg::COL_W-1:8] = din[nand_pkg::COL_W-9:0];
               3'd2:
               begin
                  // Column-only commands take no row
                  if (s.lastCmd == nand_pkg::CMD_READ || s.lastCmd == nand_pkg::CMD_LOAD)
                  begin
                     next_s.page = din[0];
                  end
               end
               default: next_s.page = s.page;
            endcase
         end
      end
      else if (latchRise && !busy &&
               (s.lastCmd == nand_pkg::CMD_LOAD || s.lastCmd == nand_pkg::CMD_RAND_IN))
      begin
         if (colValid)
         begin
            next_s.pageReg[s.col] = din;
            next_s.col = colInc(s.col);
         end
      end

      if (pulseFall)
      begin
         unique case (s.outSel)
            OUT_DATA:
            begin
               next_s.dout = colValid ? s.pageReg[s.col] : nand_pkg::ERASED;
               if (s.col < nand_pkg::COL_W'(nand_pkg::COLS - 1))
               begin
                  next_s.col = colInc(s.col);
               end
            end
            OUT_ID:
            begin
               next_s.dout = idByte(s.idIdx);
               if (s.idIdx < 3'(nand_pkg::ID_LAST))
               begin
                  next_s.idIdx = s.idIdx + 3'd1;
               end
            end
            OUT_STATUS: next_s.dout = statusByte;
            default: next_s.dout = s.dout;
         endcase
      end
      // Live status so polling needs no fresh pulse
      if (next_s.outSel == OUT_STATUS && !pulseFall)
      begin
         next_s.dout = statusByte;
      end
   end

   // ------------------------------------------------------------
   // Register
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         s <= '0;
         s.cells <= '1;
         s.pageReg <= '1;
         s.lastCmd <= nand_pkg::CMD_READ;
         s.outSel <= OUT_DATA;
         s.op <= OP_IDLE;
         s.prevLatchN <= 1'b1;
         s.prevPulseN <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   assign link.devIo = s.dout;
   assign link.devIoOe = !link.outputPulseN;
   assign link.rbOe = busy;
endmodule : nand_device

// File: src/nand_pkg.sv
package nand_pkg;
   // ------------------------------------------------------------
   // Geometry and commands
   // ------------------------------------------------------------
   localparam int COLS = 4224;
   localparam int COL_W = 13;
   localparam int ARRAY_PAGES = 2;
   localparam int ADDR_CYCLES = 5;
   localparam int COL_CYCLES = 2;
   localparam int ID_LAST = 4;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_READ_GO = 8'h30;
   localparam logic [7:0] CMD_RAND_OUT = 8'h05;
   localparam logic [7:0] CMD_RAND_OUT_GO = 8'he0;
   localparam logic [7:0] CMD_LOAD = 8'h80;
   localparam logic [7:0] CMD_RAND_IN = 8'h85;
   localparam logic [7:0] CMD_PROG_GO = 8'h10;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_ID = 8'h90;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] ID_ADDR = 8'h00;

   // ------------------------------------------------------------
   // Identification bytes
   // ------------------------------------------------------------
   // Arbitrary maker and device codes
   localparam logic [7:0] ID_MAKER = 8'h5a;
   localparam logic [7:0] ID_DEVICE = 8'h3c;
   localparam logic [1:0] CHIPS_2 = 2'b01;
   localparam logic [1:0] CELL_2LVL = 2'b00;
   localparam logic [1:0] SIMUL_1 = 2'b00;
   localparam logic [1:0] PAGE_4KB = 2'b10;
   localparam logic [1:0] SPARE_16 = 2'b01;
   localparam logic [1:0] BLOCK_256KB = 2'b10;
   localparam logic BUS_X8 = 1'b0;
   localparam logic [1:0] ECC_4BIT = 2'b10;
   localparam logic [1:0] PLANES_4 = 2'b10;
   localparam logic [2:0] PLANE_2GB = 3'b101;
   localparam logic [7:0] ID_BYTE3 = {1'b0, 1'b0, SIMUL_1, CELL_2LVL, CHIPS_2};
   localparam logic [7:0] ID_BYTE4 = {1'b0, BUS_X8, BLOCK_256KB, SPARE_16, PAGE_4KB};
   localparam logic [7:0] ID_BYTE5 = {1'b0, PLANE_2GB, PLANES_4, ECC_4BIT};

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int FETCH_US = 60;
   localparam int PROG_US = 200;
   localparam int RST_US = 5;
   localparam int FETCH_CYC = FETCH_US * CLK_MHZ;
   localparam int PROG_CYC = PROG_US * CLK_MHZ;
   localparam int RST_CYC = RST_US * CLK_MHZ;
   localparam int PULSE_NS = 21;
   localparam int CYCLE_NS = 42;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int CYCLE_CYC = (CYCLE_NS * CLK_MHZ + 999) / 1000;

   // ------------------------------------------------------------
   // Controller registers (byte addresses)
   // ------------------------------------------------------------
   localparam logic [4:0] REG_CMD = 5'h00;
   localparam logic [4:0] REG_ADDR = 5'h04;
   localparam logic [4:0] REG_DATA = 5'h08;
   localparam logic [4:0] REG_STATUS = 5'h0c;
   localparam logic [4:0] REG_CTRL = 5'h10;
endpackage : nand_pkg

// File: src/nand_link.sv
`timescale 1ns/1ps
interface nand_link (
   input logic mclk
);
   logic cmdCycle;
   logic addrCycle;
   logic latchStrobeN;
   logic outputPulseN;
   logic [7:0] hostIo;
   logic hostIoOe;
   logic [7:0] devIo;
   logic devIoOe;
   logic rbOe;
   logic wpN;
   wire [7:0] ioLine;
   wire rbLine;

   // Shared bus and pulled-up open-drain ready/busy
   assign ioLine = devIoOe ? devIo : (hostIoOe ? hostIo : 8'hff);
   assign rbLine = ~rbOe;

   modport device (
      input cmdCycle,
      input addrCycle,
      input latchStrobeN,
      input outputPulseN,
      input ioLine,
      input wpN,
      output devIo,
      output devIoOe,
      output rbOe
   );
   modport host (
      output cmdCycle,
      output addrCycle,
      output latchStrobeN,
      output outputPulseN,
      output hostIo,
      output hostIoOe,
      output wpN,
      input ioLine,
      input devIoOe,
      input rbLine
   );
endinterface : nand_link

// File: src/nand_host.sv
`timescale 1ns/1ps
module nand_host (
   input logic mclk,
   input logic nrst,
   nand_link.host link,
   input logic [4:0] address,
   input logic read,
   input logic write,
   input logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [1:0] {IDLE, LOW, HIGH, DONE} phase_e;

   typedef struct packed {
      phase_e phase;
      logic [3:0] cnt;
      logic cmdCycle;
      logic addrCycle;
      logic latchN;
      logic pulseN;
      logic [7:0] ioOut;
      logic ioOe;
      logic [7:0] rdData;
      logic wpN;
   } host_s;

   host_s s;
   host_s next_s;

   logic isWrCycle;
   logic isRdCycle;

   assign isWrCycle = write && (address == nand_pkg::REG_CMD || address == nand_pkg::REG_ADDR ||
                                address == nand_pkg::REG_DATA);
   assign isRdCycle = read && address == nand_pkg::REG_DATA;

   // ------------------------------------------------------------
   // Pin cycle sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      unique case (s.phase)
         IDLE:
         begin
            if (write && address == nand_pkg::REG_CTRL)
            begin
               next_s.wpN = writedata[0];
               next_s.phase = DONE;
            end
            else if (isWrCycle)
            begin
               // Software orders setup, addresses and confirm
               next_s.cmdCycle = (address == nand_pkg::REG_CMD);
               next_s.addrCycle = (address == nand_pkg::REG_ADDR);
               next_s.ioOut = writedata[7:0];
               next_s.ioOe = 1'b1;
               next_s.latchN = 1'b0;
               next_s.cnt = 4'(nand_pkg::PULSE_CYC - 1);
               next_s.phase = LOW;
            end
            else if (isRdCycle)
            begin
               next_s.pulseN = 1'b0;
               next_s.cnt = 4'(nand_pkg::PULSE_CYC - 1);
               next_s.phase = LOW;
            end
            else if (read || write)
            begin
               next_s.phase = DONE;
            end
         end
         LOW:
         begin
            if (s.cnt == 4'h0)
            begin
               // Sample late in the pulse, after the device has driven
               if (!s.pulseN)
               begin
                  next_s.rdData = link.ioLine;
               end
               next_s.latchN = 1'b1;
               next_s.pulseN = 1'b1;
               next_s.cnt = 4'(nand_pkg::CYCLE_CYC - nand_pkg::PULSE_CYC - 1);
               next_s.phase = HIGH;
            end
            else
            begin
               next_s.cnt = s.cnt - 4'h1;
            end
         end
         HIGH:
         begin
            if (s.cnt == 4'h0)
            begin
               next_s.cmdCycle = 1'b0;
               next_s.addrCycle = 1'b0;
               next_s.ioOe = 1'b0;
               next_s.phase = DONE;
            end
            else
            begin
               next_s.cnt = s.cnt - 4'h1;
            end
         end
         DONE: next_s.phase = IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         s <= '0;
         s.phase <= IDLE;
         s.latchN <= 1'b1;
         s.pulseN <= 1'b1;
         s.wpN <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Bus answer and pins
   // ------------------------------------------------------------
   always_comb
   begin
      readdata = 32'h0000_0000;
      if (address == nand_pkg::REG_DATA)
      begin
         readdata = {24'h00_0000, s.rdData};
      end
      else if (address == nand_pkg::REG_STATUS)
      begin
         readdata = {30'h0000_0000, s.phase != IDLE, link.rbLine};
      end
      else if (address == nand_pkg::REG_CTRL)
      begin
         readdata = {31'h0000_0000, s.wpN};
      end
   end

   // Status reads answer at once; pin cycles hold the master until done
   assign waitrequest = (isWrCycle || isRdCycle || (write && address == nand_pkg::REG_CTRL)) &&
                        s.phase != DONE;

   assign link.cmdCycle = s.cmdCycle;
   assign link.addrCycle = s.addrCycle;
   assign link.latchStrobeN = s.latchN;
   assign link.outputPulseN = s.pulseN;
   assign link.hostIo = s.ioOut;
   assign link.hostIoOe = s.ioOe;
   assign link.wpN = s.wpN;
endmodule : nand_host

// File: testbench/nand_link_properties.sv
`timescale 1ns/1ps
module nand_link_properties (
   input logic mclk,
   input logic nrst,
   input logic cmdCycle,
   input logic addrCycle,
   input logic latchStrobeN,
   input logic outputPulseN,
   input logic [7:0] hostIo,
   input logic [7:0] devIo,
   input logic devIoOe,
   input logic rbOe,
   input logic wpN
);
   // ----------------------------------------
   // Link checks
   // ----------------------------------------
   localparam int BUSY_MAX = 700;
   logic prevStrobe;
   logic statusMode;
   logic loadSeen;

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   // Ignored commands while busy must not move the mode; a lone confirm does not either
   always_ff @(posedge mclk)
   begin
      prevStrobe <= latchStrobeN;
      if (!nrst)
      begin
         statusMode <= 1'b0;
         loadSeen <= 1'b0;
      end
      else if (latchStrobeN && !prevStrobe && cmdCycle &&
               (!rbOe || hostIo == nand_pkg::CMD_STATUS || hostIo == nand_pkg::CMD_RESET))
      begin
         statusMode <= hostIo == nand_pkg::CMD_STATUS || hostIo == nand_pkg::CMD_RESET ||
                       (hostIo == nand_pkg::CMD_PROG_GO && loadSeen);
         loadSeen <= hostIo == nand_pkg::CMD_LOAD ||
                     (loadSeen && hostIo != nand_pkg::CMD_PROG_GO && hostIo != nand_pkg::CMD_RESET);
      end
   end

   sequence s_strobeLow;
      !latchStrobeN [*3] ##1 latchStrobeN;
   endsequence
   sequence s_pulseLow;
      !outputPulseN [*3] ##1 outputPulseN;
   endsequence

   property p_strobeLen;
      $fell(latchStrobeN) |-> s_strobeLow;
   endproperty
   property p_pulseLen;
      $fell(outputPulseN) |-> s_pulseLow;
   endproperty
   property p_flagsExcl;
      !(cmdCycle && addrCycle);
   endproperty
   property p_flagsStable;
      $rose(latchStrobeN) |-> $stable(hostIo) && $stable(cmdCycle) && $stable(addrCycle);
   endproperty
   property p_oeTracks;
      devIoOe == !outputPulseN;
   endproperty
   property p_fetchStart;
      $rose(latchStrobeN) && cmdCycle && hostIo == 8'h30 && !rbOe |-> ##[1:4] rbOe;
   endproperty
   property p_busyMin;
      $rose(rbOe) |-> rbOe [*8];
   endproperty
   property p_busyEnd;
      $rose(rbOe) |-> ##[1:BUSY_MAX] !rbOe;
   endproperty
   property p_status;
      $fell(outputPulseN) && statusMode |=> devIo[7] == wpN && !devIo[0] && (devIo[6] == !rbOe || $changed(rbOe));
   endproperty

   a_strobeLen: assert property (p_strobeLen) else $error("latch strobe low time wrong");
   a_pulseLen: assert property (p_pulseLen) else $error("output pulse low time wrong");
   a_flagsExcl: assert property (p_flagsExcl) else $error("command and address flags both high");
   a_flagsStable: assert property (p_flagsStable) else $error("cycle changed at latch edge");
   a_oeTracks: assert property (p_oeTracks) else $error("bus drive not tied to output pulse");
   a_fetchStart: assert property (p_fetchStart) else $error("no busy after read confirm");
   a_busyMin: assert property (p_busyMin) else $error("busy too short");
   a_busyEnd: assert property (p_busyEnd) else $error("busy never ends");
   a_status: assert property (p_status) else $error("status bits wrong");
endmodule : nand_link_properties

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic [31:0] rd;
   logic waitrequest;
   logic devBusy;
   logic [7:0] idExp [5];
   int errorCnt = 0;
   int cmpCount = 0;

   always #4 mclk = ~mclk;

   nand_link u_nand_link (.mclk(mclk));
   // Program time kept long enough to read status mid-operation
   nand_device #(.FETCH_CYCLES(20), .PROG_CYCLES(60)) u_nand_device (.mclk(mclk), .nrst(nrst),
      .link(u_nand_link), .busy(devBusy));
   nand_host u_nand_host (.mclk(mclk), .nrst(nrst), .link(u_nand_link), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   nand_link_properties u_nand_link_properties (.mclk(mclk), .nrst(nrst), .cmdCycle(u_nand_link.cmdCycle),
      .addrCycle(u_nand_link.addrCycle), .latchStrobeN(u_nand_link.latchStrobeN),
      .outputPulseN(u_nand_link.outputPulseN), .hostIo(u_nand_link.hostIo), .devIo(u_nand_link.devIo),
      .devIoOe(u_nand_link.devIoOe), .rbOe(u_nand_link.rbOe), .wpN(u_nand_link.wpN));

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic wrapUp;
      $display("Compared %0d, mismatches %0d", cmpCount, errorCnt);
      if (errorCnt == 0 && cmpCount > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrapUp

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Answer looked at mid-cycle, where it is settled; it holds up to the accepting edge
   task automatic access(input logic [4:0] a, input logic wr, input logic [31:0] d);
      int n;
      logic ok;
      @(posedge mclk);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= d;
      n = 0;
      do
      begin
         @(negedge mclk);
         ok = (waitrequest === 1'b0);
         rd = readdata;
         n++;
         @(posedge mclk);
      end
      while (!ok && n < 200);
      if (!ok)
         errorCnt++;
      read <= 1'b0;
      write <= 1'b0;
   endtask : access

   task automatic cmd(input logic [7:0] c);
      access(nand_pkg::REG_CMD, 1'b1, {24'h0, c});
   endtask : cmd

   task automatic adr(input logic [12:0] col, input logic pg, input int n);
      access(nand_pkg::REG_ADDR, 1'b1, {24'h0, col[7:0]});
      access(nand_pkg::REG_ADDR, 1'b1, {27'h0, col[12:8]});
      for (int i = 2; i < n; i++)
         access(nand_pkg::REG_ADDR, 1'b1, (i == 2) ? {31'h0, pg} : 32'h0);
   endtask : adr

   task automatic put(input logic [7:0] d);
      access(nand_pkg::REG_DATA, 1'b1, {24'h0, d});
   endtask : put

   task automatic rdByte(input string what, input logic [7:0] exp);
      access(nand_pkg::REG_DATA, 1'b0, 32'h0);
      chk(what, rd, {24'h0, exp});
   endtask : rdByte

   task automatic waitReady;
      int n;
      n = 0;
      do
      begin
         access(nand_pkg::REG_STATUS, 1'b0, 32'h0);
         n++;
      end
      while (rd[0] !== 1'b1 && n < 1000);
      if (rd[0] !== 1'b1)
         errorCnt++;
   endtask : waitReady

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (40000) @(posedge mclk);
      errorCnt++;
      wrapUp();
   end

   initial
   begin
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      access(nand_pkg::REG_STATUS, 1'b0, 32'h0);
      chk("ready after reset", rd[0], 1'b1);
      access(5'h02, 1'b0, 32'h0);
      chk("unmapped read", rd, 32'h0);
      cmd(nand_pkg::CMD_PROG_GO);
      access(nand_pkg::REG_STATUS, 1'b0, 32'h0);
      chk("lone confirm idle", rd[0], 1'b1);
      // No setup command: power-up state must already hold it
      adr(13'h0, 1'b0, 5);
      cmd(nand_pkg::CMD_READ_GO);
      access(nand_pkg::REG_STATUS, 1'b0, 32'h0);
      chk("busy in fetch", rd[0], 1'b0);
      @(negedge mclk);
      chk("busy pin in fetch", devBusy, 1'b1);
      waitReady();
      chk("busy pin after fetch", devBusy, 1'b0);
      rdByte("erased", nand_pkg::ERASED);
      cmd(nand_pkg::CMD_LOAD);
      adr(13'd3, 1'b1, 5);
      put(8'ha1);
      put(8'ha2);
      cmd(nand_pkg::CMD_RAND_IN);
      adr(13'd100, 1'b1, 2);
      put(8'hb1);
      cmd(nand_pkg::CMD_PROG_GO);
      cmd(nand_pkg::CMD_READ);
      access(nand_pkg::REG_DATA, 1'b0, 32'h0);
      chk("status busy", rd[7:0] & 8'hc1, 8'h80);
      waitReady();
      access(nand_pkg::REG_DATA, 1'b0, 32'h0);
      chk("status done", rd[7:0] & 8'hc1, 8'hc0);
      cmd(nand_pkg::CMD_READ);
      adr(13'd2, 1'b1, 5);
      cmd(nand_pkg::CMD_READ_GO);
      waitReady();
      rdByte("col2", 8'hff);
      rdByte("col3", 8'ha1);
      rdByte("col4", 8'ha2);
      rdByte("col5", 8'hff);
      cmd(nand_pkg::CMD_RAND_OUT);
      adr(13'd100, 1'b1, 2);
      cmd(nand_pkg::CMD_RAND_OUT_GO);
      rdByte("col100", 8'hb1);
      rdByte("col101", 8'hff);
      cmd(nand_pkg::CMD_RAND_OUT);
      adr(13'd3, 1'b1, 2);
      cmd(nand_pkg::CMD_RAND_OUT_GO);
      rdByte("col3 again", 8'ha1);
      idExp = '{nand_pkg::ID_MAKER, nand_pkg::ID_DEVICE, 8'h01, {2'b00, 2'b10, 2'b01, 2'b10},
         {1'b0, 3'b101, 2'b10, 2'b10}};
      cmd(nand_pkg::CMD_ID);
      access(nand_pkg::REG_ADDR, 1'b1, {24'h0, nand_pkg::ID_ADDR});
      for (int i = 0; i < 5; i++)
         rdByte("id byte", idExp[i]);
      access(nand_pkg::REG_CTRL, 1'b1, 32'h0);
      access(nand_pkg::REG_CTRL, 1'b0, 32'h0);
      chk("protect bit", rd, 32'h0);
      cmd(nand_pkg::CMD_STATUS);
      access(nand_pkg::REG_DATA, 1'b0, 32'h0);
      chk("status protected", rd[7:0] & 8'hc1, 8'h40);
      access(nand_pkg::REG_CTRL, 1'b1, 32'h1);
      cmd(nand_pkg::CMD_RESET);
      @(negedge mclk);
      chk("busy pin in reset", devBusy, 1'b1);
      waitReady();
      access(nand_pkg::REG_DATA, 1'b0, 32'h0);
      chk("status after reset", rd[7:0] & 8'hc1, 8'hc0);
      wrapUp();
   end
endmodule : tb_top
